/* File: rtl/cpei_copper_events.sv */
/*
 * Copper event flagging and interrupt masking, reached over APB.
 * Holds the enable register, the latched-high flag register, a control
 * register with a software reset request and a live status register.
 * Assumes event pulses and status levels synchronous to pclk, and that
 * the event detectors themselves sit outside this block.
 */
`timescale 1ns/10ps
`include "cpei_map.svh"

module cpei_copper_events
    import cpei_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        an_ms_fault,
    input  wire logic        an_pd_fault,
    input  wire logic        an_no_hcd,
    input  wire logic        an_link_fail,
    input  wire logic        an_page_rx,
    input  wire logic        an_complete,
    input  wire logic        rx_symbol_err,
    input  wire logic        rx_false_carrier,
    input  wire logic        speed_downshift,
    input  wire logic        flp_done_no_link,
    input  wire logic        jabber_det,
    input  wire logic [1:0]  speed_lvl,
    input  wire logic        duplex_lvl,
    input  wire logic        link_lvl,
    input  wire logic        mdix_lvl,
    input  wire logic        energy_lvl,
    input  wire logic        polarity_lvl,
    output logic             irq
);

    // ------------------------------------------------------------------
    // Carrier between bus slave and core
    // ------------------------------------------------------------------
    cpei_reg_if rif ();

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    cpei_word_t  enable_r;      // Per-event interrupt enables
    cpei_word_t  enable_nxt;    // Next enable value
    cpei_word_t  flags;         // Latched-high event flags
    logic        sreset_r;      // One-cycle software reset pulse
    logic        sreset_nxt;    // Next software reset pulse

    // Previous levels for change detection
    cpei_speed_t speed_prev_r;  // Last seen speed code
    logic        duplex_prev_r; // Last seen duplex
    logic        link_prev_r;   // Last seen link state
    logic        mdix_prev_r;   // Last seen crossover
    logic        energy_prev_r; // Last seen energy state
    logic        polar_prev_r;  // Last seen polarity
    logic        primed_r;      // Previous levels hold real samples

    // ------------------------------------------------------------------
    // Decoded access strobes
    // ------------------------------------------------------------------
    logic        wr_enable;     // Write to enable register
    logic        wr_ctrl;       // Write to control register
    logic        rd_flags;      // Completed read of flag register

    // ------------------------------------------------------------------
    // Event assembly
    // ------------------------------------------------------------------
    logic        an_error;      // Any negotiation error cause
    logic        chg_speed;     // Speed code changed
    logic        chg_duplex;    // Duplex changed
    logic        chg_link;      // Link state changed
    logic        chg_mdix;      // Crossover changed
    logic        chg_energy;    // Energy-detect state changed
    logic        chg_polar;     // Polarity changed
    cpei_word_t  evt_raw;       // Events by bit position
    cpei_word_t  evt_set;       // Events with reserved bits removed
    cpei_word_t  evt_clr;       // Bits to clear after a flag read
    cpei_word_t  live_word;     // Live status read value
    logic        irq_nxt;       // Next interrupt level

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    cpei_apb_slave u_apb (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .rif     (rif)
    );

    // ------------------------------------------------------------------
    // Address map: which indices answer
    // ------------------------------------------------------------------
    // Holes in the map answer with pslverr
    assign rif.cur_hit = (rif.cur_idx == `CPEI_IDX_ENABLE) ||
                         (rif.cur_idx == `CPEI_IDX_FLAGS)  ||
                         (rif.cur_idx == `CPEI_IDX_CTRL)   ||
                         (rif.cur_idx == `CPEI_IDX_LIVE);

    // Live levels for software inspection
    assign live_word = {8'h00,
                        speed_lvl,
                        mdix_lvl,
                        duplex_lvl,
                        polarity_lvl,
                        energy_lvl,
                        link_lvl,
                        irq};

    // Read data select; control reads as zero
    // Flags value is the snapshot a read clears
    assign rif.cur_rdata =
        (rif.cur_idx == `CPEI_IDX_ENABLE) ? enable_r  :
        (rif.cur_idx == `CPEI_IDX_FLAGS)  ? flags     :
        (rif.cur_idx == `CPEI_IDX_LIVE)   ? live_word :
                                            16'h0000;

    // ------------------------------------------------------------------
    // Access strobes; writes to flags and live are dropped
    // ------------------------------------------------------------------
    assign wr_enable = rif.wr_stb & (rif.acc_idx == `CPEI_IDX_ENABLE);
    assign wr_ctrl   = rif.wr_stb & (rif.acc_idx == `CPEI_IDX_CTRL);
    assign rd_flags  = rif.rd_stb & (rif.acc_idx == `CPEI_IDX_FLAGS);

    // Reserved enable bits are stored as zero whatever is written
    // Only a completed write moves the mask
    assign enable_nxt = wr_enable ? (rif.wdata & `CPEI_EVT_MASK)
                                  : enable_r;

    // Software reset request is a one-cycle pulse
    // Other control bits are ignored
    assign sreset_nxt = wr_ctrl & rif.wdata[`CPEI_B_SRESET];

    // ------------------------------------------------------------------
    // Enable register: hardware reset only, survives software reset
    // Software keeps its mask over a soft reset
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_r <= `CPEI_ENABLE_RST;
        end else begin
            enable_r <= enable_nxt;
        end
    end

    // Software reset pulse register
    // Flags clear one edge after the write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sreset_r <= 1'b0;
        end else begin
            sreset_r <= sreset_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Level history for change detection
    // ------------------------------------------------------------------
    // First sample after reset only primes, so no false change appears
    // A level moved in reset is no event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            primed_r <= 1'b0;
        end else begin
            primed_r <= 1'b1;
        end
    end

    // Sampled levels, always tracking the inputs
    // Soft reset leaves history alone: no false change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speed_prev_r  <= 2'h0;
            duplex_prev_r <= 1'b0;
            link_prev_r   <= 1'b0;
            mdix_prev_r   <= 1'b0;
            energy_prev_r <= 1'b0;
            polar_prev_r  <= 1'b0;
        end else begin
            speed_prev_r  <= speed_lvl;
            duplex_prev_r <= duplex_lvl;
            link_prev_r   <= link_lvl;
            mdix_prev_r   <= mdix_lvl;
            energy_prev_r <= energy_lvl;
            polar_prev_r  <= polarity_lvl;
        end
    end

    // ------------------------------------------------------------------
    // Event sources
    // ------------------------------------------------------------------
    // Pulse inputs latch on every high cycle
    // Any of the four negotiation failures counts as an error
    assign an_error   = an_ms_fault | an_pd_fault |
                        an_no_hcd | an_link_fail;

    // Resolved speed and duplex changes
    assign chg_speed  = primed_r & (speed_lvl != speed_prev_r);
    assign chg_duplex = primed_r & (duplex_lvl != duplex_prev_r);

    // Link transitions in either direction
    assign chg_link   = primed_r & (link_lvl != link_prev_r);

    // Crossover setting change
    assign chg_mdix   = primed_r & (mdix_lvl != mdix_prev_r);

    // Energy-detect state change
    assign chg_energy = primed_r & (energy_lvl != energy_prev_r);

    // Receive polarity change
    assign chg_polar  = primed_r & (polarity_lvl != polar_prev_r);

    // Events placed at their flag positions
    // Reserved bits 7 and 2 stay zero here
    always_comb begin
        evt_raw                  = 16'h0000;
        evt_raw[`CPEI_B_ANERR]   = an_error;
        evt_raw[`CPEI_B_SPEED]   = chg_speed;
        evt_raw[`CPEI_B_DUPLEX]  = chg_duplex;
        evt_raw[`CPEI_B_PAGE]    = an_page_rx;
        evt_raw[`CPEI_B_ANDONE]  = an_complete;
        evt_raw[`CPEI_B_LINK]    = chg_link;
        evt_raw[`CPEI_B_SYMERR]  = rx_symbol_err;
        evt_raw[`CPEI_B_FCARR]   = rx_false_carrier;
        evt_raw[`CPEI_B_MDIX]    = chg_mdix;
        evt_raw[`CPEI_B_DSHIFT]  = speed_downshift;
        evt_raw[`CPEI_B_ENERGY]  = chg_energy;
        evt_raw[`CPEI_B_FLPNL]   = flp_done_no_link;
        evt_raw[`CPEI_B_POLAR]   = chg_polar;
        evt_raw[`CPEI_B_JABBER]  = jabber_det;
    end

    // Reserved positions can never latch
    assign evt_set = evt_raw & `CPEI_EVT_MASK;

    // Clear only what the read returned; later events stay pending
    assign evt_clr = rd_flags ? rif.rd_val : 16'h0000;

    // ------------------------------------------------------------------
    // Flag bank: read-only to software, set wins over clear
    // Soft reset clear beats a same-cycle event
    // ------------------------------------------------------------------
    cpei_event_latch #(
        .W (16)
    ) u_flags (
        .clk    (pclk),
        .rst_n  (presetn),
        .sreset (sreset_r),
        .set    (evt_set),
        .clr    (evt_clr),
        .flags  (flags)
    );

    // ------------------------------------------------------------------
    // Interrupt: level while any enabled flag is set
    // ------------------------------------------------------------------
    assign irq_nxt = |(flags & enable_r);

    // Registered interrupt output
    // Straight from a flip-flop, one edge behind flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_nxt;
        end
    end

endmodule

/* File: rtl/cpei_map.svh */
/*
 * Register indices, field positions, masks and reset values of the copper
 * event interrupt block. Assumes an APB slave with 32-bit data where the
 * byte address of a register is four times its index.
 */
`ifndef CPEI_MAP_SVH
`define CPEI_MAP_SVH

// Register indices (byte address is index times four)
`define CPEI_IDX_ENABLE  8'h12
`define CPEI_IDX_FLAGS   8'h13
`define CPEI_IDX_CTRL    8'h14
`define CPEI_IDX_LIVE    8'h15

// Reset values
`define CPEI_ENABLE_RST  16'h0000
`define CPEI_FLAGS_RST   16'h0000

// Implemented bits of enable and flag registers (7 and 2 reserved)
`define CPEI_EVT_MASK    16'hff7b

// Event bit positions, shared by enable and flag registers
`define CPEI_B_ANERR     15
`define CPEI_B_SPEED     14
`define CPEI_B_DUPLEX    13
`define CPEI_B_PAGE      12
`define CPEI_B_ANDONE    11
`define CPEI_B_LINK      10
`define CPEI_B_SYMERR    9
`define CPEI_B_FCARR     8
`define CPEI_B_MDIX      6
`define CPEI_B_DSHIFT    5
`define CPEI_B_ENERGY    4
`define CPEI_B_FLPNL     3
`define CPEI_B_POLAR     1
`define CPEI_B_JABBER    0

// Control register: software reset request bit
`define CPEI_B_SRESET    0

// Live status register layout
`define CPEI_B_LV_IRQ    0
`define CPEI_B_LV_LINK   1
`define CPEI_B_LV_ENERGY 2
`define CPEI_B_LV_POLAR  3
`define CPEI_B_LV_DUPLEX 4
`define CPEI_B_LV_MDIX   5
`define CPEI_B_LV_SPDLO  6

`endif

/* File: rtl/cpei_pkg.sv */
/*
 * Types of the copper event interrupt block.
 * Assumes cpei_map.svh supplies the numeric constants.
 */
package cpei_pkg;
    typedef logic [15:0] cpei_word_t;  // Management register word
    typedef logic [7:0]  cpei_idx_t;   // Register index
    typedef logic [1:0]  cpei_speed_t; // Resolved speed code
endpackage

/* File: rtl/cpei_reg_if.sv */
/*
 * Register access carrier between the APB slave and the event core.
 * Assumes both ends run on pclk.
 */
`timescale 1ns/10ps
interface cpei_reg_if;
    import cpei_pkg::*;
    cpei_idx_t  cur_idx;   // Index decoded in setup phase
    logic       cur_hit;   // Index maps to a register
    cpei_word_t cur_rdata; // Read value for cur_idx
    cpei_idx_t  acc_idx;   // Index latched for the access
    logic       wr_stb;    // One-cycle write completion
    logic       rd_stb;    // One-cycle read completion
    cpei_word_t wdata;     // Write data low half
    cpei_word_t rd_val;    // Value actually returned by the read
    modport slv  (output cur_idx, acc_idx, wr_stb, rd_stb, wdata, rd_val,
                  input  cur_hit, cur_rdata);
    modport core (input  cur_idx, acc_idx, wr_stb, rd_stb, wdata, rd_val,
                  output cur_hit, cur_rdata);
endinterface

/* File: rtl/cpei_apb_slave.sv */
/*
 * APB slave with one access cycle and registered answers.
 * Assumes a well-behaved APB master on pclk and the core on the carrier.
 */
`timescale 1ns/10ps
`include "cpei_map.svh"
module cpei_apb_slave
    import cpei_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    cpei_reg_if.slv          rif
);
    logic        setup;    // Setup phase seen
    logic        done;     // Access completes this edge
    logic        hit_r;    // Setup decoded a valid word
    logic        write_r;  // Direction of the pending access
    logic        aligned;  // Word aligned, inside the map window

    // Decode in setup phase
    assign setup       = psel & ~penable;
    assign aligned     = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    assign rif.cur_idx = paddr[9:2];
    assign done        = psel & penable & pready;

    // Completion strobes toward the core
    assign rif.wr_stb  = done & write_r & hit_r;
    assign rif.rd_stb  = done & ~write_r & hit_r;
    assign rif.wdata   = pwdata[15:0];
    assign rif.rd_val  = prdata[15:0];

    // Capture answer at the setup edge; ready for one access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            prdata      <= 32'h0000_0000;
            hit_r       <= 1'b0;
            write_r     <= 1'b0;
            rif.acc_idx <= 8'h00;
        end else begin
            pready <= setup;
            if (setup) begin
                hit_r       <= rif.cur_hit & aligned;
                write_r     <= pwrite;
                rif.acc_idx <= rif.cur_idx;
                pslverr     <= ~(rif.cur_hit & aligned);
                prdata      <= (!pwrite && rif.cur_hit && aligned) ?
                               {16'h0000, rif.cur_rdata} : 32'h0000_0000;
            end
        end
    end
endmodule

/* File: rtl/cpei_event_latch.sv */
/*
 * Latched-high flag bank: set wins over read clear, soft reset clears all.
 * Assumes set, clear and soft reset are synchronous to clk.
 */
`timescale 1ns/10ps
module cpei_event_latch #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         sreset,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    output logic      [W-1:0] flags
);
    logic [W-1:0] flags_nxt; // Next flag value

    // Hold, clear read bits, then apply new events on top
    assign flags_nxt = (flags & ~clr) | set;

    // Flag storage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags <= '0;
        end else if (sreset) begin
            flags <= '0;
        end else begin
            flags <= flags_nxt;
        end
    end
endmodule

/* File: test/cpei_events_assertions.sv */
/*
 * Checker for the copper event block: bus answer timing and interrupt causes.
 * Assumes it is bound to cpei_copper_events and sees only its ports.
 */
`timescale 1ns/10ps
module cpei_events_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        an_ms_fault,
    input wire logic        an_pd_fault,
    input wire logic        an_no_hcd,
    input wire logic        an_link_fail,
    input wire logic        an_page_rx,
    input wire logic        an_complete,
    input wire logic        rx_symbol_err,
    input wire logic        rx_false_carrier,
    input wire logic        speed_downshift,
    input wire logic        flp_done_no_link,
    input wire logic        jabber_det,
    input wire logic [1:0]  speed_lvl,
    input wire logic        duplex_lvl,
    input wire logic        link_lvl,
    input wire logic        mdix_lvl,
    input wire logic        energy_lvl,
    input wire logic        polarity_lvl,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [15:0] en_r;    // Shadow of the enable register
    logic        psel_d;  // Select one cycle back
    logic        prime_r; // Level history valid
    logic [6:0]  lv_d;    // Level history
    wire  [6:0]  lv_now = {speed_lvl, duplex_lvl, link_lvl, mdix_lvl, energy_lvl, polarity_lvl};
    wire         done   = psel && penable && pready;
    wire         en_wr  = done && pwrite && paddr == 12'h048;
    wire         en_rd  = done && !pwrite && paddr == 12'h048;
    wire         fl_rd  = done && !pwrite && paddr == 12'h04c;
    wire         quiet  = !psel && !psel_d;
    wire  [6:0]  dif    = prime_r ? lv_now ^ lv_d : 7'h00;
    // Level changes placed on their flag positions
    wire  [15:0] chg = {1'b0, |dif[6:5], dif[4], 2'b00, dif[3], 3'b000, dif[2], 1'b0, dif[1],
                        2'b00, dif[0], 1'b0};
    // Pulse events placed on their flag positions
    wire  [15:0] pul = {an_ms_fault | an_pd_fault | an_no_hcd | an_link_fail, 2'b00, an_page_rx,
                        an_complete, 1'b0, rx_symbol_err, rx_false_carrier, 2'b00,
                        speed_downshift, 1'b0, flp_done_no_link, 2'b00, jabber_det};
    // Track enable writes and history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_r    <= 16'h0000;
            psel_d  <= 1'b0;
            prime_r <= 1'b0;
            lv_d    <= 7'h00;
        end else begin
            if (en_wr) begin
                en_r <= pwdata[15:0] & 16'hff7b;
            end
            psel_d  <= psel;
            prime_r <= 1'b1;
            lv_d    <= lv_now;
        end
    end
    property p_ready_next;
        psel && !penable |=> pready;
    endproperty
    a_ready_next: assert property (p_ready_next)
        else $error("no pready after setup");
    property p_pulse_irq;
        (|(pul & en_r)) && quiet ##1 !psel |=> irq;
    endproperty
    a_pulse_irq: assert property (p_pulse_irq)
        else $error("enabled pulse event gave no interrupt");
    property p_change_irq;
        (|(chg & en_r)) && quiet ##1 !psel |=> irq;
    endproperty
    a_change_irq: assert property (p_change_irq)
        else $error("enabled level change gave no interrupt");
    property p_irq_needs_en;
        irq |-> $past(en_r) != 16'h0000;
    endproperty
    a_irq_needs_en: assert property (p_irq_needs_en)
        else $error("interrupt with nothing enabled");
    property p_irq_hold;
        irq && quiet && !$past(psel, 2) |=> irq;
    endproperty
    a_irq_hold: assert property (p_irq_hold)
        else $error("interrupt dropped without any clearing access");
    property p_rsv_flags;
        fl_rd |-> prdata[31:16] == 16'h0000 && !prdata[7] && !prdata[2];
    endproperty
    a_rsv_flags: assert property (p_rsv_flags)
        else $error("reserved flag bit read as one");
    property p_en_read;
        en_rd |-> prdata == {16'h0000, en_r};
    endproperty
    a_en_read: assert property (p_en_read)
        else $error("enable readback differs from written value");
    property p_mask_off;
        en_wr && (pwdata[15:0] & 16'hff7b) == 16'h0000 |=> ##1 !irq;
    endproperty
    a_mask_off: assert property (p_mask_off)
        else $error("interrupt stayed with all enables off");
endmodule

bind cpei_copper_events cpei_events_chk i_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .an_ms_fault, .an_pd_fault, .an_no_hcd, .an_link_fail, .an_page_rx, .an_complete,
    .rx_symbol_err, .rx_false_carrier, .speed_downshift, .flp_done_no_link, .jabber_det,
    .speed_lvl, .duplex_lvl, .link_lvl, .mdix_lvl, .energy_lvl, .polarity_lvl, .irq
);

/* File: test/testbench.sv */
/*
 * Self-checking bench for the copper event block: event table, then masking,
 * read-clear races, software and hardware reset. Assumes the APB slave timing
 * and register indices of cpei_map.svh.
 */
`timescale 1ns/10ps
`include "cpei_map.svh"
module testbench;
    import cpei_pkg::*;
    localparam logic [11:0] adr_en = 12'({`CPEI_IDX_ENABLE, 2'b00}); // Enable register
    localparam logic [11:0] adr_fl = 12'({`CPEI_IDX_FLAGS, 2'b00});  // Flag register
    localparam logic [11:0] adr_ct = 12'({`CPEI_IDX_CTRL, 2'b00});   // Control register
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, perr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [10:0] pls;  // Pulse events, index order of the table
    logic [1:0]  spd;  // Speed level
    logic [4:0]  lvl;  // Duplex, link, crossover, energy, polarity
    int          fail_count, total_checks;
    // Row i: one-hot stimulus i (11 pulses, speed, 5 levels) and flags it gives
    cpei_word_t  exp_f [17] = '{16'h8000, 16'h8000, 16'h8000, 16'h8000, 16'h1000, 16'h0800,
                               16'h0200, 16'h0100, 16'h0020, 16'h0008, 16'h0001, 16'h4000,
                               16'h2000, 16'h0400, 16'h0040, 16'h0010, 16'h0002};
    cpei_copper_events i_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .an_ms_fault(pls[0]), .an_pd_fault(pls[1]), .an_no_hcd(pls[2]),
        .an_link_fail(pls[3]), .an_page_rx(pls[4]), .an_complete(pls[5]),
        .rx_symbol_err(pls[6]), .rx_false_carrier(pls[7]), .speed_downshift(pls[8]),
        .flp_done_no_link(pls[9]), .jabber_det(pls[10]), .speed_lvl(spd),
        .duplex_lvl(lvl[0]), .link_lvl(lvl[1]), .mdix_lvl(lvl[2]), .energy_lvl(lvl[3]),
        .polarity_lvl(lvl[4]), .irq
    );
    // Clock, 20 ns period
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // Verdict and end of run
    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // One comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1); // A hang is ended by the watchdog
        q = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string m);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(q, e, m);
    endtask
    // Raise stimulus i for one cycle (levels toggle once)
    task automatic hit(input int i);
        @(posedge pclk);
        if (i < 11)
            pls <= 11'(1) << i;
        else if (i == 11)
            spd <= spd ^ 2'b01;
        else
            lvl <= lvl ^ (5'(1) << (i - 12));
        @(posedge pclk);
        pls <= '0;
    endtask
    task automatic irq_is(input logic e, input string m);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, {31'h0, e}, m);
    endtask
    // Watchdog, far beyond the expected run
    initial begin
        #100000;
        fail_count++;
        $display("[ERR] %0t watchdog expired", $time);
        summarize();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pls, spd, lvl} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(adr_en, 32'h0, "enable reset");
        rd(adr_fl, 32'h0, "flags reset");
        wr(adr_en, 32'h0000ff7b);
        rd(adr_en, 32'h0000ff7b, "enable reserved");
        // Event table: each row latches exactly its flag
        for (int i = 0; i < 17; i++) begin
            hit(i);
            irq_is(1'b1, "irq on event");
            rd(adr_fl, {16'h0, exp_f[i]}, "flag");
            rd(adr_fl, 32'h0, "flag after read");
            irq_is(1'b0, "irq after read");
        end
        // Masking: disabled flag stays quiet until enabled
        wr(adr_en, 32'h00000001);
        rd(adr_en, 32'h00000001, "enable write");
        hit(6);
        irq_is(1'b0, "masked flag");
        wr(adr_en, 32'h00000200);
        irq_is(1'b1, "unmasked flag");
        wr(adr_en, 32'h0);
        irq_is(1'b0, "masked again");
        wr(adr_fl, 32'hffffffff);
        rd(adr_fl, 32'h00000200, "flag sticky, not writable");
        rd(12'h7fc, 32'h0, "unmapped read");
        chk({31'h0, perr}, 32'h1, "unmapped error");
        // Event at the clearing edge survives
        hit(10);
        fork
            rd(adr_fl, 32'h1, "race first read");
            begin
                repeat (2) @(posedge pclk);
                pls <= 11'h400;
                @(posedge pclk);
                pls <= '0;
            end
        join
        rd(adr_fl, 32'h1, "race event kept");
        // Software reset keeps enables, clears flags
        wr(adr_en, 32'h0000ff7b);
        hit(10);
        wr(adr_ct, 32'h1);
        repeat (2) @(posedge pclk);
        rd(adr_en, 32'h0000ff7b, "enable kept");
        rd(adr_fl, 32'h0, "flags soft reset");
        chk({31'h0, irq}, 32'h0, "irq soft reset");
        // Hardware reset in mid-run
        hit(10);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0, "irq in reset");
        presetn <= 1'b1;
        rd(adr_en, 32'h0, "enable hw reset");
        rd(adr_fl, 32'h0, "flags hw reset");
        rd(12'({`CPEI_IDX_LIVE, 2'b00}), 32'h7e, "live levels");
        summarize();
    end
endmodule
